// ===== bench/opd_decoder_bench.sv
// Self-checking bench for the first-page opcode decoder.
`timescale 1ns/1ps
`default_nettype none
module opd_decoder_bench;
    import opd_pkg::*;
    logic sys_clk, rst_b, op_valid, page2_active, cyc_go, rel_go, illegal_op, hx_inc;
    logic [7:0] op_byte, vec_low, wr_data, rel_offset, rdata;
    logic [15:0] eff_addr, sp_in, hx_in, pc, hx_next, m_pc;
    logic [31:0] r;
    opd_bus_t cyc_code;
    opd_decode_t dec;
    opd_busreq_t bus_req;
    int miscompares, check_count, seed;
    opd_mode_t mode_tab [6] = '{OPD_IMMEDIATE, OPD_DIRECT, OPD_EXTENDED, OPD_IX_16BIT,
        OPD_IX_8BIT, OPD_IX_NOOFF};
    opd_decoder dut (.sys_clk(sys_clk), .rst_b(rst_b), .op_valid(op_valid), .op_byte(op_byte),
        .page2_active(page2_active), .cyc_go(cyc_go), .cyc_code(cyc_code),
        .eff_addr(eff_addr), .vec_low(vec_low), .wr_data(wr_data), .sp_in(sp_in),
        .hx_in(hx_in), .rel_go(rel_go), .rel_offset(rel_offset), .dec(dec),
        .illegal_op(illegal_op), .bus_req(bus_req), .pc(pc), .hx_next(hx_next),
        .hx_inc(hx_inc));
    opd_prog_mem u_mem (.sys_clk(sys_clk), .bus_req(bus_req), .rdata(rdata));
    // ----
    // Checking helpers
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
        check_count++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Class, length and cycle count of the opcodes with fixed figures; bit 10 marks known.
    function automatic logic [10:0] exp_row(input logic [7:0] o);
        case (o)
            8'h41, 8'h51: return {1'b1, OPD_CLS_CMP_BRANCH, 2'h3, 4'h4};
            8'h4B, 8'h5B: return {1'b1, OPD_CLS_DEC_BRANCH, 2'h2, 4'h4};
            8'h8E: return {1'b1, OPD_CLS_STOP, 2'h1, 4'h2};
            8'h8F: return {1'b1, OPD_CLS_WAIT, 2'h1, 4'h2};
            8'h82: return {1'b1, OPD_CLS_DEBUG, 2'h1, 4'h5};
            8'hAD, 8'hBD: return {1'b1, OPD_CLS_CALL, 2'h2, 4'h5};
            default: ;
        endcase
        case (o[7:4])
            4'h0: return {1'b1, OPD_CLS_BIT_BRANCH, 2'h3, 4'h5};
            4'h1: return {1'b1, OPD_CLS_BIT_WRITE, 2'h2, 4'h5};
            4'h2: return {1'b1, OPD_CLS_BRANCH, 2'h2, 4'h3};
            default: return 11'h0;
        endcase
    endfunction
    task automatic chk_dec(input logic [7:0] o);
        logic [10:0] row;
        row = exp_row(o);
        chk(illegal_op, {31'h0, o == 8'h8D || o == 8'hAC}, "illegal flag");
        if (o == 8'h8D || o == 8'hAC) chk(dec.op_class, OPD_CLS_NONE, "hole class");
        if (row[10]) chk({dec.op_class, dec.bytes, dec.cycles}, row[9:0], "class");
        if (o[7:5] == 3'h0)
            chk({dec.bit_index, dec.bit_polarity}, {o[3:1], ~o[0]}, "bit");
        if (o[7:4] == 4'h2 || o == 8'hAD) chk(dec.mode, OPD_RELATIVE, "rel mode");
        if (o inside {8'h8E, 8'h8F, 8'h82}) chk(dec.cycles_open, 1'b1, "open");
        if (o == 8'h8F) chk(dec.clear_int_mask, 1'b1, "mask");
        if (o == OPC_PREBYTE)
            chk({dec.page2_next, dec.op_class}, {1'b1, OPD_CLS_PREBYTE}, "pre");
        if (o < 8'hA0 || o == 8'hAC || o == 8'hAD) return;
        chk(dec.mode, mode_tab[o[7:4] - 4'hA], "mode");
        chk(dec.operand_bytes,
            o[7:4] inside {4'hC, 4'hD} ? 2 : o[7:4] == 4'hF ? 0 : 1, "opnd");
        if (o[3:0] == 4'h0) chk(dec.sub_op, LN_SUBTRACT, "subtract");
        if (o[7:4] == 4'hF)
            chk(dec.cycles, o[2:0] == 3'h7 ? 2 : o[3:0] == 4'hD ? 5 : 3, "ix");
    endtask
    task automatic check_cycle();
        logic [15:0] a;
        logic [1:0] rw;
        a = m_pc;
        rw = cyc_code inside {OPD_BUS_OPWR, OPD_BUS_PUSH} ? 2'h1 : 2'h2;
        case (cyc_code)
            OPD_BUS_OPRD, OPD_BUS_OPWR: a = eff_addr;
            OPD_BUS_PUSH, OPD_BUS_POP: a = sp_in;
            OPD_BUS_VEC_HI: a = {VECTOR_PAGE, vec_low};
            OPD_BUS_VEC_LO: a = {VECTOR_PAGE, vec_low | 8'h01};
            default: ;
        endcase
        if (!cyc_go) chk(bus_req, 32'h0, "idle bus");
        else chk({bus_req.rd, bus_req.wr, bus_req.addr}, {rw, a}, "bus");
        if (cyc_go && rw == 2'h1) chk(bus_req.wdata, wr_data, "write data");
        if (rel_go) m_pc = m_pc + {{8{rel_offset[7]}}, rel_offset};
        else if (cyc_go && cyc_code == OPD_BUS_FETCH) m_pc = m_pc + 16'h1;
        chk(pc, m_pc, "pc");
        chk(16'(hx_in + 16'h1), hx_next, "index next");
        // First-page decode never selects post-increment, so no increment is signalled.
        chk(hx_inc, 32'h0, "post increment");
        if (!op_valid || page2_active) chk(dec, 32'h0, "quiet decode");
        else chk_dec(op_byte);
    endtask
    // ----
    // Stimulus
    // ----
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        #(2_000_000);
        miscompares++;
        give_verdict();
    end
    initial begin
        seed = 32'hcd2350b1;
        {rst_b, op_valid, page2_active, cyc_go, rel_go, op_byte, vec_low} = '0;
        {wr_data, rel_offset, eff_addr, sp_in, hx_in} = '0;
        cyc_code = OPD_BUS_FREE;
        m_pc = 16'h0;
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        @(negedge sys_clk);
        chk(dec, 32'h0, "reset decode");
        chk(pc, 32'h0, "reset pc");
        // A sweep of every opcode first, then program memory bytes while a read is requested, random bytes otherwise.
        for (int n = 0; n < 1500; n++) begin
            r = $random(seed);
            op_byte = n < 256 ? n[7:0] : bus_req.rd ? rdata : r[7:0];
            op_valid = n < 256 || r[10:8] != 3'h0;
            page2_active = n >= 256 && r[13:11] == 3'h0;
            cyc_go = r[16:14] != 3'h0;
            cyc_code = opd_bus_t'(r[19:17]);
            rel_go = r[22:20] == 3'h0;
            rel_offset = {r[31:25], r[23]};
            {eff_addr, sp_in} = $random(seed);
            {hx_in, vec_low, wr_data} = $random(seed);
            @(negedge sys_clk);
            check_cycle();
        end
        give_verdict();
    end
endmodule
`default_nettype wire

// ===== bench/opd_decoder_monitor.sv
// Checker of decode results and bus cycles at the decoder's ports.
`timescale 1ns/1ps
`default_nettype none
module opd_decoder_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Inputs of the decoder
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    input wire logic page2_active,
    input wire logic cyc_go,
    input wire opd_pkg::opd_bus_t cyc_code,
    input wire logic [15:0] eff_addr,
    input wire logic [7:0] vec_low,
    input wire logic [7:0] wr_data,
    input wire logic [15:0] sp_in,
    input wire logic [15:0] hx_in,
    input wire logic rel_go,
    input wire logic [7:0] rel_offset,
    // Outputs of the decoder
    input wire opd_pkg::opd_decode_t dec,
    input wire logic illegal_op,
    input wire opd_pkg::opd_busreq_t bus_req,
    input wire logic [15:0] pc,
    input wire logic [15:0] hx_next,
    input wire logic hx_inc
);
    import opd_pkg::*;
    // ----
    // Properties
    // ----
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    logic take;
    logic plain;
    assign take = op_valid && !page2_active;
    assign plain = cyc_go && !rel_go;
    a_bit_test_dec: assert property (take && op_byte[7:4] == 4'h0 |=>
        dec.op_class == OPD_CLS_BIT_BRANCH && dec.bytes == 2'h3 && dec.cycles == 4'h5
        && dec.bit_index == $past(op_byte[3:1]) && dec.bit_polarity == !$past(op_byte[0]))
        else $error("bit test decode wrong");
    a_bit_write_dec: assert property (take && op_byte[7:4] == 4'h1 |=>
        dec.op_class == OPD_CLS_BIT_WRITE && dec.bytes == 2'h2 && dec.cycles == 4'h5)
        else $error("bit write decode wrong");
    a_rel_branch_dec: assert property (take && op_byte[7:4] == 4'h2 |=>
        dec.op_class == OPD_CLS_BRANCH && dec.bytes == 2'h2 && dec.cycles == 4'h3)
        else $error("branch decode wrong");
    a_prebyte_quiet: assert property (!take |=> dec == '0)
        else $error("decode not suppressed");
    a_hole_flagged: assert property (take && op_byte inside {8'h8D, 8'hAC} |=>
        illegal_op && dec.illegal)
        else $error("empty opcode not flagged");
    a_ix_store_fast: assert property (take && op_byte inside {8'hF7, 8'hFF} |=>
        dec.cycles == 4'h2)
        else $error("indexed store cycles wrong");
    a_free_read: assert property (plain && cyc_code == OPD_BUS_FREE |=>
        bus_req.rd && !bus_req.wr && bus_req.addr == $past(pc) && $stable(pc))
        else $error("free cycle wrong");
    a_fetch_advance: assert property (plain && cyc_code == OPD_BUS_FETCH |=>
        bus_req.rd && bus_req.addr == $past(pc) && pc == $past(pc) + 16'h1)
        else $error("fetch wrong");
    a_vector_high: assert property (cyc_go && cyc_code == OPD_BUS_VEC_HI |=>
        bus_req.rd && bus_req.addr == {8'hFF, $past(vec_low)})
        else $error("vector high address wrong");
    a_push_write: assert property (cyc_go && cyc_code == OPD_BUS_PUSH |=>
        bus_req.wr && !bus_req.rd && bus_req.addr == $past(sp_in)
        && bus_req.wdata == $past(wr_data))
        else $error("push wrong");
    a_rel_target: assert property (rel_go |=>
        pc == $past(pc) + {{8{$past(rel_offset[7])}}, $past(rel_offset)})
        else $error("branch target wrong");
    c_prebyte: cover property (take && op_byte == OPC_PREBYTE);
    c_vec_low: cover property (cyc_go && cyc_code == OPD_BUS_VEC_LO);
    c_rel_fetch: cover property (rel_go && cyc_go && cyc_code == OPD_BUS_FETCH);
endmodule
bind opd_decoder opd_decoder_monitor u_mon (.sys_clk(sys_clk), .rst_b(rst_b),
    .op_valid(op_valid), .op_byte(op_byte), .page2_active(page2_active), .cyc_go(cyc_go),
    .cyc_code(cyc_code), .eff_addr(eff_addr), .vec_low(vec_low), .wr_data(wr_data),
    .sp_in(sp_in), .hx_in(hx_in), .rel_go(rel_go), .rel_offset(rel_offset), .dec(dec),
    .illegal_op(illegal_op), .bus_req(bus_req), .pc(pc), .hx_next(hx_next), .hx_inc(hx_inc));
`default_nettype wire

// ===== bench/opd_prog_mem.sv
// Program memory model answering the decoder's bus requests.
`timescale 1ns/1ps
`default_nettype none
module opd_prog_mem (
    // Clock
    input wire logic sys_clk,
    // Bus request and read data
    input wire opd_pkg::opd_busreq_t bus_req,
    output logic [7:0] rdata
);
    import opd_pkg::*;
    // Two-state storage starts at zero, so no unknown reaches the decoder.
    bit [7:0] mem [65536];
    bit written [65536];
    bit [7:0] last_r;
    // Unwritten places read a pattern that follows the address.
    always_comb begin
        if (!bus_req.rd) begin
            rdata = ~last_r;
        end else if (written[bus_req.addr]) begin
            rdata = mem[bus_req.addr];
        end else begin
            rdata = bus_req.addr[7:0] ^ bus_req.addr[15:8];
        end
    end
    always_ff @(posedge sys_clk) begin
        last_r <= rdata;
        if (bus_req.wr) begin
            mem[bus_req.addr] <= bus_req.wdata;
            written[bus_req.addr] <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== core/opd_bus_cycle.sv
// Bus cycle address and direction generator for one activity code.
`timescale 1ns/1ps
`default_nettype none
module opd_bus_cycle (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Cycle request
    input wire logic cyc_go,
    input wire opd_pkg::opd_bus_t cyc_code,
    input wire logic [15:0] eff_addr,
    input wire logic [7:0] vec_low,
    input wire logic [7:0] wr_data,
    input wire logic [15:0] pc_load,
    input wire logic pc_load_en,
    input wire logic [15:0] sp_in,
    input wire logic [15:0] hx_in,
    input wire logic postinc,
    // Outputs
    output opd_pkg::opd_busreq_t bus_req,
    output logic [15:0] pc,
    output logic [15:0] hx_next,
    output logic hx_inc
);
    import opd_pkg::*;
    logic [15:0] pc_r;
    opd_busreq_t req_r;
    logic [15:0] hx_next_r;
    logic hx_inc_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pc_r <= 16'h0000;
        end else if (pc_load_en) begin
            pc_r <= pc_load;
        end else if (cyc_go && cyc_code == OPD_BUS_FETCH) begin
            pc_r <= pc_r + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            req_r <= '0;
        end else if (!cyc_go) begin
            req_r <= '0;
        end else begin
            req_r.wr <= 1'b0;
            req_r.rd <= 1'b1;
            req_r.wdata <= 8'h00;
            case (cyc_code)
                OPD_BUS_FREE: req_r.addr <= pc_r;
                OPD_BUS_FETCH: req_r.addr <= pc_r;
                OPD_BUS_OPRD: req_r.addr <= postinc ? hx_in : eff_addr;
                OPD_BUS_OPWR: begin
                    req_r.addr <= postinc ? hx_in : eff_addr;
                    req_r.wdata <= wr_data;
                    req_r.rd <= 1'b0;
                    req_r.wr <= 1'b1;
                end
                OPD_BUS_PUSH: begin
                    req_r.addr <= sp_in;
                    req_r.wdata <= wr_data;
                    req_r.rd <= 1'b0;
                    req_r.wr <= 1'b1;
                end
                OPD_BUS_POP: req_r.addr <= sp_in;
                OPD_BUS_VEC_HI: req_r.addr <= {VECTOR_PAGE, vec_low};
                OPD_BUS_VEC_LO: req_r.addr <= {VECTOR_PAGE, vec_low | 8'h01};
                default: req_r.addr <= pc_r;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            hx_inc_r <= 1'b0;
            hx_next_r <= 16'h0000;
        end else begin
            hx_inc_r <= cyc_go && postinc &&
                (cyc_code == OPD_BUS_OPRD || cyc_code == OPD_BUS_OPWR);
            hx_next_r <= hx_in + 16'h0001;
        end
    end

    assign bus_req = req_r;
    assign pc = pc_r;
    assign hx_next = hx_next_r;
    assign hx_inc = hx_inc_r;
endmodule
`default_nettype wire

// ===== core/opd_decoder.sv
// First-page opcode decoder with bus cycle generation.
`timescale 1ns/1ps
`default_nettype none
module opd_decoder (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Opcode stream
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    input wire logic page2_active,
    // Bus cycle request
    input wire logic cyc_go,
    input wire opd_pkg::opd_bus_t cyc_code,
    input wire logic [15:0] eff_addr,
    input wire logic [7:0] vec_low,
    input wire logic [7:0] wr_data,
    input wire logic [15:0] sp_in,
    input wire logic [15:0] hx_in,
    // Relative target
    input wire logic rel_go,
    input wire logic [7:0] rel_offset,
    // Decode outputs
    output opd_pkg::opd_decode_t dec,
    output logic illegal_op,
    // Bus outputs
    output opd_pkg::opd_busreq_t bus_req,
    output logic [15:0] pc,
    output logic [15:0] hx_next,
    output logic hx_inc
);
    import opd_pkg::*;

    // ----------------------------------------
    // Combinational decode
    // ----------------------------------------
    opd_decode_t d_nxt;
    opd_decode_t dec_r;
    logic [3:0] hi;
    logic [3:0] lo;

    always_comb begin
        hi = op_byte[7:4];
        lo = op_byte[3:0];
        d_nxt = '0;
        d_nxt.valid = op_valid && !page2_active;
        d_nxt.op_class = OPD_CLS_OTHER;
        d_nxt.mode = OPD_OTHER;
        d_nxt.bytes = 2'd1;
        d_nxt.cycles = CYC_UNKNOWN;
        d_nxt.sub_op = lo;
        case (hi)
            4'h0: begin
                d_nxt.op_class = OPD_CLS_BIT_BRANCH;
                d_nxt.mode = OPD_DIRECT;
                d_nxt.bytes = 2'd3;
                d_nxt.operand_bytes = 2'd1;
                d_nxt.cycles = CYC_BIT_BRANCH;
                d_nxt.bit_index = op_byte[3:1];
                d_nxt.bit_polarity = ~op_byte[0];
            end
            4'h1: begin
                d_nxt.op_class = OPD_CLS_BIT_WRITE;
                d_nxt.mode = OPD_DIRECT;
                d_nxt.bytes = 2'd2;
                d_nxt.operand_bytes = 2'd1;
                d_nxt.cycles = CYC_BIT_WRITE;
                d_nxt.bit_index = op_byte[3:1];
                d_nxt.bit_polarity = ~op_byte[0];
            end
            4'h2: begin
                d_nxt.op_class = OPD_CLS_BRANCH;
                d_nxt.mode = OPD_RELATIVE;
                d_nxt.bytes = 2'd2;
                d_nxt.operand_bytes = 2'd1;
                d_nxt.cycles = CYC_REL_BRANCH;
            end
            4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: begin
                d_nxt.op_class = (lo == LN_SUB_JUMP) ? OPD_CLS_CALL
                                                     : OPD_CLS_REG_MEM;
                case (hi)
                    4'hA: begin
                        d_nxt.mode = OPD_IMMEDIATE;
                        d_nxt.operand_bytes = 2'd1;
                        d_nxt.cycles = CYC_RM_IMMED;
                    end
                    4'hB: begin
                        d_nxt.mode = OPD_DIRECT;
                        d_nxt.operand_bytes = 2'd1;
                        d_nxt.cycles = (lo == LN_SUB_JUMP) ? CYC_CALL_DIR : CYC_RM_DIR;
                    end
                    4'hC: begin
                        d_nxt.mode = OPD_EXTENDED;
                        d_nxt.operand_bytes = 2'd2;
                        d_nxt.cycles = (lo == LN_SUB_JUMP) ? CYC_CALL_ABS : CYC_RM_ABS;
                    end
                    4'hD: begin
                        d_nxt.mode = OPD_IX_16BIT;
                        d_nxt.operand_bytes = 2'd2;
                        d_nxt.cycles = (lo == LN_SUB_JUMP) ? CYC_CALL_IDX16 : CYC_RM_IDX16;
                    end
                    4'hE: begin
                        d_nxt.mode = OPD_IX_8BIT;
                        d_nxt.operand_bytes = 2'd1;
                        d_nxt.cycles = (lo == LN_SUB_JUMP) ? CYC_CALL_IDX8 : CYC_RM_IDX8;
                    end
                    default: begin
                        d_nxt.mode = OPD_IX_NOOFF;
                        d_nxt.operand_bytes = 2'd0;
                        d_nxt.cycles = (lo == LN_SUB_JUMP) ? CYC_CALL_IX : CYC_IX_OTHER;
                    end
                endcase
                if (op_byte == OPC_STORE_ACC_IX || op_byte == OPC_STORE_IDX_IX) begin
                    d_nxt.cycles = CYC_IX_STORE;
                end
                if (op_byte == OPC_REL_CALL) begin
                    d_nxt.mode = OPD_RELATIVE;
                    d_nxt.cycles = CYC_CALL_REL;
                end
                d_nxt.bytes = d_nxt.operand_bytes + 2'd1;
            end
            default: begin
                d_nxt.op_class = OPD_CLS_OTHER;
            end
        endcase
        case (op_byte)
            OPC_CMP_ACC_BEQ, OPC_CMP_IDX_BEQ: begin
                d_nxt.op_class = OPD_CLS_CMP_BRANCH;
                d_nxt.mode = OPD_IMMEDIATE;
                d_nxt.bytes = 2'd3;
                d_nxt.operand_bytes = 2'd2;
                d_nxt.cycles = CYC_CMP_DEC_BR;
                d_nxt.use_index_reg = (op_byte == OPC_CMP_IDX_BEQ);
            end
            OPC_DEC_ACC_BNZ, OPC_DEC_IDX_BNZ: begin
                d_nxt.op_class = OPD_CLS_DEC_BRANCH;
                d_nxt.mode = OPD_INHERENT;
                d_nxt.bytes = 2'd2;
                d_nxt.operand_bytes = 2'd1;
                d_nxt.cycles = CYC_CMP_DEC_BR;
                d_nxt.use_index_reg = (op_byte == OPC_DEC_IDX_BNZ);
            end
            OPC_STOP, OPC_WAIT: begin
                d_nxt.op_class = (op_byte == OPC_WAIT) ? OPD_CLS_WAIT : OPD_CLS_STOP;
                d_nxt.mode = OPD_INHERENT;
                d_nxt.bytes = 2'd1;
                d_nxt.operand_bytes = 2'd0;
                d_nxt.cycles = CYC_STOP_WAIT;
                d_nxt.cycles_open = 1'b1;
                d_nxt.clear_int_mask = (op_byte == OPC_WAIT);
            end
            OPC_DEBUG_ENTRY: begin
                d_nxt.op_class = OPD_CLS_DEBUG;
                d_nxt.mode = OPD_INHERENT;
                d_nxt.bytes = 2'd1;
                d_nxt.operand_bytes = 2'd0;
                d_nxt.cycles = CYC_DEBUG_ENTRY;
                d_nxt.cycles_open = 1'b1;
            end
            OPC_PREBYTE: begin
                d_nxt.op_class = OPD_CLS_PREBYTE;
                d_nxt.page2_next = 1'b1;
                d_nxt.cycles = 4'h0;
            end
            OPC_HOLE_CTRL, OPC_HOLE_REGMEM: begin
                d_nxt.op_class = OPD_CLS_NONE;
                d_nxt.illegal = 1'b1;
                d_nxt.cycles = 4'h0;
            end
            default: begin
                d_nxt.illegal = d_nxt.illegal;
            end
        endcase
        if (!d_nxt.valid) begin
            d_nxt = '0;
        end
    end

    // ----------------------------------------
    // Registered decode result
    // ----------------------------------------
    // Registering costs a cycle but keeps the sequencer's inputs glitch free.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            dec_r <= '0;
        end else begin
            dec_r <= d_nxt;
        end
    end

    // ----------------------------------------
    // Relative target and bus cycles
    // ----------------------------------------
    logic [15:0] rel_target;
    assign rel_target = pc + {{8{rel_offset[7]}}, rel_offset};

    opd_bus_cycle u_bus (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .cyc_go(cyc_go),
        .cyc_code(cyc_code),
        .eff_addr(eff_addr),
        .vec_low(vec_low),
        .wr_data(wr_data),
        .pc_load(rel_target),
        .pc_load_en(rel_go),
        .sp_in(sp_in),
        .hx_in(hx_in),
        .postinc(dec_r.mode == OPD_IX_POSTINC),
        .bus_req(bus_req),
        .pc(pc),
        .hx_next(hx_next),
        .hx_inc(hx_inc)
    );

    assign dec = dec_r;
    assign illegal_op = dec_r.illegal;
endmodule
`default_nettype wire

// ===== core/opd_pkg.sv
// Package of constants and types for the first-page opcode decoder.
// Operation
// - 00-0F bit test-and-branch, 3 bytes, 5 cycles
// - 10-1F bit set/clear, 2 bytes, 5 cycles
// - 20-2F relative branch, 2 bytes, 3 cycles
// - Free cycle: no bus need, one read cycle
// - Fetch reads next byte, advances address
// - Vector read from top page, high first
// - Push writes one byte at stack pointer
// - Pop reads one byte from stack
// - Operand read moves byte from effective address
// - Operand write drives byte to effective address
// - Post-increment mode uses index then increments
// - Relative offset byte added to program counter
// - Operand fields zero, one or two bytes by mode
// - 9E is prebyte selecting second page
// - 8E/8F one byte, at least 2 cycles
// - 82 background debug, one byte, 5+ cycles
// - 41/51 compare-branch-equal, 3 bytes, 4 cycles
// - 4B/5B decrement-branch-nonzero, 2 bytes, 4 cycles
// - A0-FF high nibble mode, low nibble operation
// - F7/FF take 2 cycles, FD 5, other no-offset indexed 3
// - AD relative call; D-nibble row subroutine jumps
// - Wait clears interrupt mask, halts until interrupt
package opd_pkg;
    // ----------------------------------------
    // Opcode constants
    // ----------------------------------------
    localparam logic [7:0] OPC_PREBYTE = 8'h9E;
    localparam logic [7:0] OPC_STOP = 8'h8E;
    localparam logic [7:0] OPC_WAIT = 8'h8F;
    localparam logic [7:0] OPC_DEBUG_ENTRY = 8'h82;
    localparam logic [7:0] OPC_CMP_ACC_BEQ = 8'h41;
    localparam logic [7:0] OPC_CMP_IDX_BEQ = 8'h51;
    localparam logic [7:0] OPC_DEC_ACC_BNZ = 8'h4B;
    localparam logic [7:0] OPC_DEC_IDX_BNZ = 8'h5B;
    localparam logic [7:0] OPC_STORE_ACC_IX = 8'hF7;
    localparam logic [7:0] OPC_STORE_IDX_IX = 8'hFF;
    localparam logic [7:0] OPC_REL_CALL = 8'hAD;
    localparam logic [7:0] OPC_HOLE_CTRL = 8'h8D;
    localparam logic [7:0] OPC_HOLE_REGMEM = 8'hAC;
    localparam logic [3:0] LN_SUBTRACT = 4'h0;
    localparam logic [3:0] LN_SUB_JUMP = 4'hD;
    localparam logic [7:0] VECTOR_PAGE = 8'hFF;
    // ----------------------------------------
    // Cycle counts of the decoded opcodes
    // ----------------------------------------
    localparam logic [3:0] CYC_BIT_BRANCH = 4'h5;
    localparam logic [3:0] CYC_BIT_WRITE = 4'h5;
    localparam logic [3:0] CYC_REL_BRANCH = 4'h3;
    localparam logic [3:0] CYC_STOP_WAIT = 4'h2;
    localparam logic [3:0] CYC_DEBUG_ENTRY = 4'h5;
    localparam logic [3:0] CYC_CMP_DEC_BR = 4'h4;
    localparam logic [3:0] CYC_IX_STORE = 4'h2;
    localparam logic [3:0] CYC_IX_OTHER = 4'h3;
    localparam logic [3:0] CYC_CALL_REL = 4'h5;
    localparam logic [3:0] CYC_CALL_DIR = 4'h5;
    localparam logic [3:0] CYC_CALL_ABS = 4'h6;
    localparam logic [3:0] CYC_CALL_IDX16 = 4'h6;
    localparam logic [3:0] CYC_CALL_IDX8 = 4'h5;
    localparam logic [3:0] CYC_CALL_IX = 4'h5;
    localparam logic [3:0] CYC_RM_IMMED = 4'h2;
    localparam logic [3:0] CYC_RM_DIR = 4'h3;
    localparam logic [3:0] CYC_RM_ABS = 4'h4;
    localparam logic [3:0] CYC_RM_IDX16 = 4'h4;
    localparam logic [3:0] CYC_RM_IDX8 = 4'h3;
    localparam logic [3:0] CYC_UNKNOWN = 4'h1;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [3:0] {
        OPD_INHERENT = 4'h0, OPD_IMMEDIATE = 4'h1, OPD_DIRECT = 4'h2,
        OPD_EXTENDED = 4'h3, OPD_IX_NOOFF = 4'h4, OPD_IX_8BIT = 4'h5,
        OPD_IX_16BIT = 4'h6, OPD_RELATIVE = 4'h7, OPD_IX_POSTINC = 4'h8,
        OPD_OTHER = 4'hF
    } opd_mode_t;
    typedef enum logic [3:0] {
        OPD_CLS_NONE = 4'h0, OPD_CLS_BIT_BRANCH = 4'h1, OPD_CLS_BIT_WRITE = 4'h2,
        OPD_CLS_BRANCH = 4'h3, OPD_CLS_CMP_BRANCH = 4'h4, OPD_CLS_DEC_BRANCH = 4'h5,
        OPD_CLS_REG_MEM = 4'h6, OPD_CLS_CALL = 4'h7, OPD_CLS_STOP = 4'h8,
        OPD_CLS_WAIT = 4'h9, OPD_CLS_DEBUG = 4'hA, OPD_CLS_PREBYTE = 4'hB,
        OPD_CLS_OTHER = 4'hC
    } opd_class_t;
    // Bus activity codes of a single cycle.
    typedef enum logic [2:0] {
        OPD_BUS_FREE = 3'h0, OPD_BUS_FETCH = 3'h1, OPD_BUS_OPRD = 3'h2,
        OPD_BUS_OPWR = 3'h3, OPD_BUS_PUSH = 3'h4, OPD_BUS_POP = 3'h5,
        OPD_BUS_VEC_HI = 3'h6, OPD_BUS_VEC_LO = 3'h7
    } opd_bus_t;
    typedef struct packed {
        logic valid;
        logic illegal;
        logic page2_next;
        opd_class_t op_class;
        opd_mode_t mode;
        logic [1:0] bytes;
        logic [1:0] operand_bytes;
        logic [3:0] cycles;
        logic cycles_open;
        logic [3:0] sub_op;
        logic [2:0] bit_index;
        logic bit_polarity;
        logic use_index_reg;
        logic clear_int_mask;
    } opd_decode_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } opd_busreq_t;
endpackage
